// ---- src/arith_logic_opcode_decoder.v ----
/*
 Decoder for the arithmetic and logic instruction group: walks opcode, mod-reg-r/m,
 displacement and immediate bytes and reports the decoded operation once complete.
 Assumes the prefetch queue presents one byte per cycle with byteValid, synchronous
 to clk, and that every valid byte is taken; bytes outside the group are handed on.
*/
`timescale 1ns/100ps
`include "alu_decode_consts.vh"

module arith_logic_opcode_decoder (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Byte stream from the prefetch queue
	input wire byteValid,
	input wire [7:0] byteIn,
	// Decoded instruction
	output wire instValid,
	output wire [5:0] opKind,
	output wire wordSize,
	output wire directionToReg,
	output wire signExtendImm,
	output wire countFromCl,
	output wire flagsOnly,
	output wire accForm,
	output wire regForm,
	output wire hasModrm,
	output wire [1:0] modField,
	output wire [2:0] regField,
	output wire [2:0] rmField,
	output wire [15:0] dispWord,
	output wire [15:0] immWord,
	output wire [1:0] immCount,
	// Hand-off of foreign bytes
	output wire passValid,
	output wire [1:0] passCount,
	output wire [7:0] passByte0,
	output wire [7:0] passByte1
);

	reg [2:0] stReg;
	reg [3:0] formReg;
	reg [5:0] opReg;
	reg [7:0] firstReg;
	reg [7:0] modrmReg;
	reg wReg;
	reg dReg;
	reg sReg;
	reg vReg;
	reg [1:0] dispLeftReg;
	reg [1:0] dispTotalReg;
	reg [1:0] immLeftReg;
	reg [1:0] immTotalReg;
	reg [15:0] dispReg;
	reg [15:0] immReg;
	reg doneReg;
	reg flagsReg;
	reg passReg;
	reg [1:0] passCntReg;

	reg [9:0] firstDec;
	reg [5:0] opNext;
	reg finishNow;
	reg passNow;
	reg [1:0] dispCnt;
	reg [1:0] immCnt;

	function [5:0] aluOp;
		input [2:0] mid;
		begin
			case (mid)
				3'h0: aluOp = `OP_SUM_PLAIN;
				3'h1: aluOp = `OP_BITWISE_DISJUNCTION;
				3'h2: aluOp = `OP_SUM_WITH_CARRY;
				3'h3: aluOp = `OP_DIFFERENCE_WITH_BORROW;
				3'h4: aluOp = `OP_BITWISE_CONJUNCTION;
				3'h5: aluOp = `OP_DIFFERENCE_PLAIN;
				3'h6: aluOp = `OP_BITWISE_EXCLUSIVE_DISJUNCTION;
				default: aluOp = `OP_COMPARE_FLAGS_ONLY;
			endcase
		end
	endfunction

	// Form and kind from the opcode byte alone
	function [9:0] firstDecode;
		input [7:0] b;
		begin
			casez (b)
				8'b00???0??: firstDecode = {`FORM_MODRM, aluOp(b[5:3])};
				8'b00???10?: firstDecode = {`FORM_ACC, aluOp(b[5:3])};
				8'b00110111: firstDecode = {`FORM_ONE, `OP_ASCII_FIX_AFTER_SUM};
				8'b00100111: firstDecode = {`FORM_ONE, `OP_BCD_FIX_AFTER_SUM};
				8'b00111111: firstDecode = {`FORM_ONE, `OP_ASCII_FIX_AFTER_DIFFERENCE};
				8'b00101111: firstDecode = {`FORM_ONE, `OP_BCD_FIX_AFTER_DIFFERENCE};
				8'b01000???: firstDecode = {`FORM_REG, `OP_PLUS_ONE};
				8'b01001???: firstDecode = {`FORM_REG, `OP_MINUS_ONE};
				8'b100000??: firstDecode = {`FORM_GRP_IMM, `OP_NONE};
				8'b1000010?: firstDecode = {`FORM_MODRM, `OP_FLAG_ONLY_CONJUNCTION};
				8'b1010100?: firstDecode = {`FORM_ACC, `OP_FLAG_ONLY_CONJUNCTION};
				8'b1111011?: firstDecode = {`FORM_GRP_UNARY, `OP_NONE};
				8'b1111111?: firstDecode = {`FORM_GRP_STEP, `OP_NONE};
				8'b110100??: firstDecode = {`FORM_SHIFT, `OP_NONE};
				8'b11010100: firstDecode = {`FORM_TWO, `OP_ASCII_FIX_AFTER_PRODUCT};
				8'b11010101: firstDecode = {`FORM_TWO, `OP_ASCII_FIX_BEFORE_QUOTIENT};
				8'b10011000: firstDecode = {`FORM_ONE, `OP_BYTE_TO_WORD_EXTEND};
				8'b10011001: firstDecode = {`FORM_ONE, `OP_WORD_TO_DOUBLE_EXTEND};
				default: firstDecode = {`FORM_PASS, `OP_NONE};
			endcase
		end
	endfunction

	// Kind selected by the middle field of the second byte
	function [5:0] groupOp;
		input [3:0] form;
		input [5:0] cur;
		input [2:0] mid;
		begin
			case (form)
				`FORM_GRP_IMM: groupOp = aluOp(mid);
				`FORM_GRP_UNARY: begin
					case (mid)
						3'h0: groupOp = `OP_FLAG_ONLY_CONJUNCTION;
						3'h2: groupOp = `OP_BITWISE_INVERT;
						3'h3: groupOp = `OP_SIGN_FLIP;
						3'h4: groupOp = `OP_UNSIGNED_PRODUCT;
						3'h5: groupOp = `OP_SIGNED_PRODUCT;
						3'h6: groupOp = `OP_UNSIGNED_QUOTIENT;
						3'h7: groupOp = `OP_SIGNED_QUOTIENT;
						default: groupOp = `OP_NONE;
					endcase
				end
				`FORM_GRP_STEP: begin
					case (mid)
						3'h0: groupOp = `OP_PLUS_ONE;
						3'h1: groupOp = `OP_MINUS_ONE;
						default: groupOp = `OP_NONE;
					endcase
				end
				`FORM_SHIFT: begin
					case (mid)
						3'h0: groupOp = `OP_LEFT_ROTATE;
						3'h1: groupOp = `OP_RIGHT_ROTATE;
						3'h2: groupOp = `OP_LEFT_ROTATE_THROUGH_CARRY;
						3'h3: groupOp = `OP_RIGHT_ROTATE_THROUGH_CARRY;
						3'h4: groupOp = `OP_LEFT_SHIFT;
						3'h5: groupOp = `OP_LOGICAL_RIGHT_SHIFT;
						3'h7: groupOp = `OP_ARITH_RIGHT_SHIFT;
						default: groupOp = `OP_NONE;
					endcase
				end
				default: groupOp = cur;
			endcase
		end
	endfunction

	// Completion, hand-off and byte counts for the current byte
	always @* begin
		firstDec = firstDecode(byteIn);
		opNext = opReg;
		finishNow = 1'b0;
		passNow = 1'b0;
		dispCnt = 2'h0;
		immCnt = 2'h0;
		case (stReg)
			`ST_IDLE: begin
				if (byteValid) begin
					opNext = firstDec[5:0];
					if (firstDec[9:6] == `FORM_ONE || firstDec[9:6] == `FORM_REG)
						finishNow = 1'b1;
					if (firstDec[9:6] == `FORM_PASS)
						passNow = 1'b1;
				end
			end
			`ST_MODRM: begin
				if (byteValid) begin
					opNext = groupOp(formReg, opReg, byteIn[5:3]);
					if (byteIn[7:6] == `MOD_DISP8)
						dispCnt = 2'h1;
					else if (byteIn[7:6] == `MOD_DISP16)
						dispCnt = 2'h2;
					else if (byteIn[7:6] == 2'h0 && byteIn[2:0] == `RM_DIRECT)
						dispCnt = 2'h2;
					if (formReg == `FORM_GRP_IMM)
						immCnt = ({sReg, wReg} == 2'b01) ? 2'h2 : 2'h1;
					else if (formReg == `FORM_GRP_UNARY && byteIn[5:3] == 3'h0)
						immCnt = wReg ? 2'h2 : 2'h1;
					if (opNext == `OP_NONE)
						passNow = 1'b1;
					else if (dispCnt == 2'h0 && immCnt == 2'h0)
						finishNow = 1'b1;
				end
			end
			`ST_DISP: begin
				if (byteValid && dispLeftReg == 2'h1 && immLeftReg == 2'h0)
					finishNow = 1'b1;
			end
			`ST_IMM: begin
				if (byteValid && immLeftReg == 2'h1)
					finishNow = 1'b1;
			end
			`ST_SECOND: begin
				if (byteValid) begin
					if (byteIn == `ADJUST_SECOND_BYTE)
						finishNow = 1'b1;
					else
						passNow = 1'b1;
				end
			end
			default: begin
				finishNow = 1'b0;
			end
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stReg <= `ST_IDLE;
			formReg <= `FORM_PASS;
			opReg <= `OP_NONE;
			firstReg <= 8'h00;
			modrmReg <= 8'h00;
			wReg <= 1'b0;
			dReg <= 1'b0;
			sReg <= 1'b0;
			vReg <= 1'b0;
			dispLeftReg <= 2'h0;
			dispTotalReg <= 2'h0;
			immLeftReg <= 2'h0;
			immTotalReg <= 2'h0;
			dispReg <= 16'h0000;
			immReg <= 16'h0000;
			doneReg <= 1'b0;
			flagsReg <= 1'b0;
			passReg <= 1'b0;
			passCntReg <= 2'h0;
		end else begin
			doneReg <= finishNow;
			passReg <= passNow;
			opReg <= opNext;
			if (finishNow) begin
				flagsReg <= (opNext == `OP_COMPARE_FLAGS_ONLY) ||
					(opNext == `OP_FLAG_ONLY_CONJUNCTION);
				stReg <= `ST_IDLE;
			end
			case (stReg)
				`ST_IDLE: begin
					if (byteValid) begin
						firstReg <= byteIn;
						formReg <= firstDec[9:6];
						modrmReg <= 8'h00;
						dispReg <= 16'h0000;
						immReg <= 16'h0000;
						dispTotalReg <= 2'h0;
						immTotalReg <= 2'h0;
						passCntReg <= 2'h1;
						// Register form carries its register in the low bits, always a word
						wReg <= (firstDec[9:6] == `FORM_REG) ? 1'b1 : byteIn[0];
						dReg <= (firstDec[9:6] == `FORM_MODRM) ? byteIn[1] : 1'b0;
						sReg <= (firstDec[9:6] == `FORM_GRP_IMM) ? byteIn[1] : 1'b0;
						vReg <= (firstDec[9:6] == `FORM_SHIFT) ? byteIn[1] : 1'b0;
						if (firstDec[9:6] == `FORM_REG)
							modrmReg <= {`MOD_REGISTER, 3'h0, byteIn[2:0]};
						case (firstDec[9:6])
							`FORM_MODRM, `FORM_GRP_IMM, `FORM_GRP_UNARY,
							`FORM_GRP_STEP, `FORM_SHIFT: stReg <= `ST_MODRM;
							`FORM_TWO: stReg <= `ST_SECOND;
							`FORM_ACC: begin
								stReg <= `ST_IMM;
								immLeftReg <= byteIn[0] ? 2'h2 : 2'h1;
								immTotalReg <= byteIn[0] ? 2'h2 : 2'h1;
							end
							default: stReg <= `ST_IDLE;
						endcase
					end
				end
				`ST_MODRM: begin
					if (byteValid) begin
						modrmReg <= byteIn;
						dispLeftReg <= dispCnt;
						dispTotalReg <= dispCnt;
						immLeftReg <= immCnt;
						immTotalReg <= immCnt;
						if (passNow) begin
							passCntReg <= 2'h2;
							stReg <= `ST_IDLE;
						end else if (!finishNow)
							stReg <= (dispCnt != 2'h0) ? `ST_DISP : `ST_IMM;
					end
				end
				`ST_DISP: begin
					if (byteValid) begin
						// Displacement precedes data; short form is sign extended
						if (dispLeftReg == dispTotalReg)
							dispReg <= {(modrmReg[7:6] == `MOD_DISP8) ?
								{8{byteIn[7]}} : 8'h00, byteIn};
						else
							dispReg[15:8] <= byteIn;
						dispLeftReg <= dispLeftReg - 2'h1;
						if (dispLeftReg == 2'h1 && !finishNow)
							stReg <= `ST_IMM;
					end
				end
				`ST_IMM: begin
					if (byteValid) begin
						if (immLeftReg == immTotalReg)
							immReg <= {({sReg, wReg} == 2'b11) ?
								{8{byteIn[7]}} : 8'h00, byteIn};
						else
							immReg[15:8] <= byteIn;
						immLeftReg <= immLeftReg - 2'h1;
					end
				end
				`ST_SECOND: begin
					if (byteValid) begin
						modrmReg <= byteIn;
						passCntReg <= 2'h2;
						stReg <= `ST_IDLE;
					end
				end
				default: begin
					stReg <= `ST_IDLE;
				end
			endcase
		end
	end

	assign instValid = doneReg;
	assign opKind = opReg;
	assign wordSize = wReg;
	assign directionToReg = dReg;
	assign signExtendImm = sReg;
	assign countFromCl = vReg;
	assign flagsOnly = flagsReg;
	assign accForm = (formReg == `FORM_ACC);
	assign regForm = (formReg == `FORM_REG);
	assign hasModrm = (formReg != `FORM_ACC) && (formReg != `FORM_ONE) &&
		(formReg != `FORM_REG) && (formReg != `FORM_TWO) && (formReg != `FORM_PASS);
	assign modField = modrmReg[7:6];
	assign regField = modrmReg[5:3];
	assign rmField = modrmReg[2:0];
	assign dispWord = dispReg;
	assign immWord = immReg;
	assign immCount = immTotalReg;
	assign passValid = passReg;
	assign passCount = passCntReg;
	assign passByte0 = firstReg;
	assign passByte1 = modrmReg;

endmodule // arith_logic_opcode_decoder

// ---- inc/alu_decode_consts.vh ----
/*
 Constants for the arithmetic and logic opcode decoder: states, forms, kinds, field codes.
 Assumes inclusion by bare name from a file that uses these macros.
*/
// Operation
// - Sum: 000000dw with mod-reg-r/m, 100000sw /000 with immediate, 0000010w with data.
// - Sum with carry: 000100dw, 100000sw /010, accumulator 0001010w.
// - Difference: 001010dw, 100000sw /101, accumulator 0010110w.
// - Difference with borrow: 000110dw, 100000sw /011, accumulator 0001110w.
// - Compare: 001110dw, 100000sw /111, 0011110w; flags only, no result written.
// - Immediate forms 100000sw take a second data byte only when s:w is 01.
// - Plus one: 1111111w /000 with r/m, or one-byte 01000 plus register.
// - Minus one: 1111111w /001 or 01001 plus register; sign flip: 1111011w /011.
// - Byte 00110111 is ascii fix after sum, 00100111 bcd fix after sum.
// - Byte 00111111 is ascii fix after difference, 00101111 bcd fix after difference.
// - 1111011w /100 unsigned product, /101 signed product, multiplier from r/m.
// - 1111011w /110 unsigned quotient, /111 signed quotient, divisor from r/m.
// - 11010100 00001010 and 11010101 00001010 are two-byte ascii fixes.
// - Byte 10011000 extends byte to word, 10011001 word to double.
// - 110100vw middle field selects shift or rotate kind.
// - Conjunction: 001000dw, 1000000w /100 with data, accumulator 0010010w.
// - Flag-only conjunction: 1000010w, 1111011w /000 with data, 1010100w.
// - Disjunction 000010dw, /001, 0000110w; exclusive 001100dw, /110, 0011010w.
// - Direction bit 1 makes the reg field the destination, 0 the source.
// - Word bit 1 means 16-bit operands, 0 means 8-bit operands.
// - With s:w equal 11 the single data byte is sign extended.
// - Shift count is one when v is 0, from the count register when 1.
`ifndef ALU_DECODE_CONSTS_VH
`define ALU_DECODE_CONSTS_VH

`define ST_IDLE 3'h0
`define ST_MODRM 3'h1
`define ST_DISP 3'h2
`define ST_IMM 3'h3
`define ST_SECOND 3'h4

`define FORM_PASS 4'h0
`define FORM_MODRM 4'h1
`define FORM_ACC 4'h2
`define FORM_ONE 4'h3
`define FORM_REG 4'h4
`define FORM_GRP_IMM 4'h5
`define FORM_GRP_UNARY 4'h6
`define FORM_GRP_STEP 4'h7
`define FORM_SHIFT 4'h8
`define FORM_TWO 4'h9

`define OP_NONE 6'h00
`define OP_SUM_PLAIN 6'h01
`define OP_SUM_WITH_CARRY 6'h02
`define OP_DIFFERENCE_PLAIN 6'h03
`define OP_DIFFERENCE_WITH_BORROW 6'h04
`define OP_COMPARE_FLAGS_ONLY 6'h05
`define OP_PLUS_ONE 6'h06
`define OP_MINUS_ONE 6'h07
`define OP_SIGN_FLIP 6'h08
`define OP_ASCII_FIX_AFTER_SUM 6'h09
`define OP_BCD_FIX_AFTER_SUM 6'h0A
`define OP_ASCII_FIX_AFTER_DIFFERENCE 6'h0B
`define OP_BCD_FIX_AFTER_DIFFERENCE 6'h0C
`define OP_UNSIGNED_PRODUCT 6'h0D
`define OP_SIGNED_PRODUCT 6'h0E
`define OP_UNSIGNED_QUOTIENT 6'h0F
`define OP_SIGNED_QUOTIENT 6'h10
`define OP_ASCII_FIX_AFTER_PRODUCT 6'h11
`define OP_ASCII_FIX_BEFORE_QUOTIENT 6'h12
`define OP_BYTE_TO_WORD_EXTEND 6'h13
`define OP_WORD_TO_DOUBLE_EXTEND 6'h14
`define OP_BITWISE_INVERT 6'h15
`define OP_LEFT_SHIFT 6'h16
`define OP_LOGICAL_RIGHT_SHIFT 6'h17
`define OP_ARITH_RIGHT_SHIFT 6'h18
`define OP_LEFT_ROTATE 6'h19
`define OP_RIGHT_ROTATE 6'h1A
`define OP_LEFT_ROTATE_THROUGH_CARRY 6'h1B
`define OP_RIGHT_ROTATE_THROUGH_CARRY 6'h1C
`define OP_BITWISE_CONJUNCTION 6'h1D
`define OP_FLAG_ONLY_CONJUNCTION 6'h1E
`define OP_BITWISE_DISJUNCTION 6'h1F
`define OP_BITWISE_EXCLUSIVE_DISJUNCTION 6'h20

`define ADJUST_SECOND_BYTE 8'h0A
`define MOD_REGISTER 2'h3
`define MOD_DISP8 2'h1
`define MOD_DISP16 2'h2
`define RM_DIRECT 3'h6

`endif

// ---- test/alu_decode_props.sv ----
/*
 Port checker for the arithmetic and logic opcode decoder.
 Assumes it is bound to the decoder and sees only its ports.
*/
`timescale 1ns/100ps

module alu_decode_props (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Byte stream
	input wire byteValid,
	input wire [7:0] byteIn,
	// Decoded instruction
	input wire instValid,
	input wire passValid,
	input wire [5:0] opKind,
	input wire wordSize,
	input wire signExtendImm,
	input wire flagsOnly,
	input wire regForm,
	input wire [1:0] modField,
	input wire [15:0] immWord,
	input wire [1:0] immCount
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	answer_delay_a: assert property (
		(instValid || passValid) |-> $past(byteValid) && !(instValid && passValid))
		else $error("pulse without a byte taken");
	adjust_sum_a: assert property (
		instValid && (opKind == 6'h09 || opKind == 6'h0A)
		|-> $past(byteIn) == (opKind == 6'h09 ? 8'h37 : 8'h27) && immCount == 2'h0)
		else $error("sum adjust code wrong");
	adjust_diff_a: assert property (
		instValid && (opKind == 6'h0B || opKind == 6'h0C)
		|-> $past(byteIn) == (opKind == 6'h0B ? 8'h3F : 8'h2F))
		else $error("difference adjust code wrong");
	extend_code_a: assert property (
		instValid && (opKind == 6'h13 || opKind == 6'h14)
		|-> $past(byteIn) == (opKind == 6'h13 ? 8'h98 : 8'h99))
		else $error("extend code wrong");
	two_byte_fix_a: assert property (
		instValid && (opKind == 6'h11 || opKind == 6'h12) |-> $past(byteIn) == 8'h0A)
		else $error("two-byte fix second byte wrong");
	sign_ext_a: assert property (
		instValid && signExtendImm && wordSize
		|-> immCount == 2'h1 && immWord[15:8] == {8{immWord[7]}})
		else $error("immediate not sign extended");
	word_imm_a: assert property (
		instValid && immCount != 2'h0 && wordSize && !signExtendImm |-> immCount == 2'h2)
		else $error("word immediate not two bytes");
	byte_imm_a: assert property (
		instValid && immCount != 2'h0 && !wordSize |-> immCount == 2'h1 && immWord[15:8] == 8'h00)
		else $error("byte immediate wrong");
	flags_only_a: assert property (
		instValid |-> flagsOnly == (opKind == 6'h05 || opKind == 6'h1E))
		else $error("flags only flag wrong");
	reg_form_a: assert property (
		instValid && regForm |-> modField == 2'h3 && wordSize && (opKind == 6'h06 || opKind == 6'h07))
		else $error("register form fields wrong");
endmodule // alu_decode_props

bind arith_logic_opcode_decoder alu_decode_props i_alu_decode_props (.clk(clk), .rstn(rstn),
	.byteValid(byteValid), .byteIn(byteIn), .instValid(instValid), .passValid(passValid),
	.opKind(opKind), .wordSize(wordSize), .signExtendImm(signExtendImm), .flagsOnly(flagsOnly),
	.regForm(regForm), .modField(modField), .immWord(immWord), .immCount(immCount));

// ---- test/prefetch_feeder.sv ----
/*
 Prefetch queue model: hands queued bytes to the decoder, one per cycle.
 Assumes the bench queues entries with put; bit 8 set queues an idle cycle.
*/
`timescale 1ns/100ps

module prefetch_feeder (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Byte stream
	output logic byteValid = 1'b0,
	output logic [7:0] byteIn = 8'h00
);
	logic [8:0] pend [$];
	logic [8:0] e;

	task put(input logic [8:0] ent);
		pend.push_back(ent);
	endtask

	// Idle lane shows the inverse of the last value
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			byteValid <= 1'b0;
		end else if (pend.size() == 0) begin
			byteValid <= 1'b0;
			byteIn <= ~byteIn;
		end else begin
			e = pend.pop_front();
			byteValid <= !e[8];
			byteIn <= e[8] ? ~byteIn : e[7:0];
		end
	end
endmodule // prefetch_feeder

// ---- test/arith_logic_opcode_decoder_bench.sv ----
/*
 Self-checking bench for the opcode decoder, fed by the prefetch queue model.
 Assumes the model and checker are compiled before it.
*/
`timescale 1ns/100ps

module arith_logic_opcode_decoder_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	wire byteValid, instValid, wordSize, directionToReg, signExtendImm, countFromCl;
	wire flagsOnly, accForm, regForm, hasModrm, passValid;
	wire [7:0] byteIn, passByte0, passByte1;
	wire [5:0] opKind;
	wire [1:0] modField, immCount, passCount;
	wire [2:0] regField, rmField;
	wire [15:0] dispWord, immWord;
	int err_total = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [7:0] accCode [0:7] = '{8'h04, 8'h14, 8'h2C, 8'h1C, 8'h3C, 8'h24, 8'h0C, 8'h34};
	logic [5:0] accOp [0:7] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h1D, 6'h1F, 6'h20};
	logic [5:0] grpOp [0:7] = '{6'h01, 6'h1F, 6'h02, 6'h04, 6'h1D, 6'h03, 6'h20, 6'h05};
	logic [5:0] unOp [0:7] = '{6'h1E, 6'h00, 6'h15, 6'h08, 6'h0D, 6'h0E, 6'h0F, 6'h10};
	logic [5:0] shOp [0:7] = '{6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h16, 6'h17, 6'h00, 6'h18};
	logic [7:0] fixCode [0:5] = '{8'h37, 8'h27, 8'h3F, 8'h2F, 8'h98, 8'h99};
	logic [5:0] fixOp [0:5] = '{6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h13, 6'h14};

	prefetch_feeder i_prefetch_feeder (.clk(clk), .rstn(rstn), .byteValid(byteValid),
		.byteIn(byteIn));

	arith_logic_opcode_decoder i_arith_logic_opcode_decoder (.clk(clk), .rstn(rstn),
		.byteValid(byteValid), .byteIn(byteIn), .instValid(instValid), .opKind(opKind),
		.wordSize(wordSize), .directionToReg(directionToReg), .signExtendImm(signExtendImm),
		.countFromCl(countFromCl), .flagsOnly(flagsOnly), .accForm(accForm), .regForm(regForm),
		.hasModrm(hasModrm), .modField(modField), .regField(regField), .rmField(rmField),
		.dispWord(dispWord), .immWord(immWord), .immCount(immCount), .passValid(passValid),
		.passCount(passCount), .passByte0(passByte0), .passByte1(passByte1));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			$display("MISMATCH run length expected end seen hang");
			close_out();
		end
	end

	task close_out;
		$display("TB: errors %0d checks %0d", err_total, n_checks);
		if (err_total == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task put(input logic [7:0] b);
		i_prefetch_feeder.put({1'b0, b});
	endtask

	// Waits for the next decoder pulse and checks which kind it was
	task take(input logic wantPass);
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (!(instValid === 1'b1 || passValid === 1'b1) && i < 40);
		chk("any pulse", 16'h0001, {15'h0, instValid | passValid});
		chk("pass pulse", {15'h0, wantPass}, {15'h0, passValid});
	endtask

	task t_acc;
		int k;
		put(8'h05);
		i_prefetch_feeder.put(9'h100);
		put(8'h34);
		put(8'h12);
		take(1'b0);
		chk("acc kind", 16'h0001, {10'h0, opKind});
		chk("acc form", 16'h0001, {15'h0, accForm});
		chk("acc no modrm", 16'h0000, {15'h0, hasModrm});
		chk("acc word imm", 16'h1234, immWord);
		for (k = 0; k < 8; k++) begin
			put(accCode[k]);
			put(8'h9C);
			take(1'b0);
			chk("acc byte kind", {10'h0, accOp[k]}, {10'h0, opKind});
			chk("acc byte imm", 16'h009C, immWord);
		end
		put(8'hA8);
		put(8'h9C);
		take(1'b0);
		chk("test acc kind", 16'h001E, {10'h0, opKind});
	endtask

	task t_modrm;
		int k;
		for (k = 0; k < 8; k++) begin
			put(accCode[k] - 8'h01);
			put(8'hD8);
			take(1'b0);
			chk("modrm kind", {10'h0, accOp[k]}, {10'h0, opKind});
			chk("modrm dir", 16'h0001, {15'h0, directionToReg});
			chk("modrm reg", 16'h0003, {13'h0, regField});
			chk("modrm has byte", 16'h0001, {15'h0, hasModrm});
		end
		put(8'h85);
		put(8'hD8);
		take(1'b0);
		chk("test dir", 16'h0000, {15'h0, directionToReg});
		put(8'h02);
		put(8'h46);
		put(8'h80);
		take(1'b0);
		chk("disp8 value", 16'hFF80, dispWord);
		chk("byte size", 16'h0000, {15'h0, wordSize});
	endtask

	task t_grp;
		int k;
		for (k = 0; k < 8; k++) begin
			put(8'h81);
			put({2'b11, 3'(k), 3'b001});
			put(8'h34);
			put(8'h12);
			take(1'b0);
			chk("group kind", {10'h0, grpOp[k]}, {10'h0, opKind});
			chk("group count", 16'h0002, {14'h0, immCount});
		end
		put(8'h83);
		put(8'hC0);
		put(8'hFF);
		take(1'b0);
		chk("sign ext imm", 16'hFFFF, immWord);
		put(8'h82);
		put(8'hC0);
		put(8'h80);
		take(1'b0);
		chk("byte imm s1", 16'h0080, immWord);
		put(8'h80);
		put(8'h86);
		put(8'h34);
		put(8'h12);
		put(8'h55);
		take(1'b0);
		chk("disp16 kind", 16'h0001, {10'h0, opKind});
		chk("disp16 value", 16'h1234, dispWord);
		chk("disp16 imm", 16'h0055, immWord);
		chk("disp16 imm count", 16'h0001, {14'h0, immCount});
	endtask

	task t_unary;
		int k;
		for (k = 0; k < 8; k++) begin
			put(8'hF7);
			put({2'b11, 3'(k), 3'b010});
			if (k == 0) begin
				put(8'h34);
				put(8'h12);
			end
			take(k == 1);
			chk("unary kind", {10'h0, unOp[k]}, {10'h0, opKind});
		end
		put(8'h43);
		take(1'b0);
		chk("reg plus kind", 16'h0006, {10'h0, opKind});
		chk("reg plus num", 16'h0003, {13'h0, rmField});
		put(8'hFE);
		put(8'hC9);
		take(1'b0);
		chk("minus kind", 16'h0007, {10'h0, opKind});
		put(8'hFF);
		put(8'h06);
		put(8'h78);
		put(8'h56);
		take(1'b0);
		chk("plus mem kind", 16'h0006, {10'h0, opKind});
		chk("plus mem disp", 16'h5678, dispWord);
	endtask

	task t_shift;
		int k;
		logic v;
		for (k = 0; k < 8; k++) begin
			v = k[0];
			put({6'b110100, v, 1'b1});
			put({2'b11, 3'(k), 3'b000});
			take(k == 6);
			if (k != 6) begin
				chk("shift kind", {10'h0, shOp[k]}, {10'h0, opKind});
				chk("shift count src", {15'h0, v}, {15'h0, countFromCl});
			end
		end
	endtask

	task t_fixes;
		int k;
		for (k = 0; k < 6; k++) begin
			put(fixCode[k]);
		end
		for (k = 0; k < 6; k++) begin
			take(1'b0);
			chk("one byte kind", {10'h0, fixOp[k]}, {10'h0, opKind});
		end
		put(8'hD4);
		put(8'h0A);
		take(1'b0);
		chk("fix product", 16'h0011, {10'h0, opKind});
		put(8'hD5);
		i_prefetch_feeder.put(9'h100);
		put(8'h0A);
		take(1'b0);
		chk("fix quotient", 16'h0012, {10'h0, opKind});
		put(8'hD4);
		put(8'h0B);
		take(1'b1);
		chk("bad fix count", 16'h0002, {14'h0, passCount});
		put(8'h90);
		take(1'b1);
		chk("foreign byte", 16'h0190, {6'h0, passCount, passByte0});
		put(8'hFF);
		put(8'h10);
		take(1'b1);
		chk("foreign second", 16'h0010, {8'h0, passByte1});
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_acc();
		t_modrm();
		t_grp();
		t_unary();
		t_shift();
		t_fixes();
		repeat (3) @(posedge clk);
		close_out();
	end
endmodule // arith_logic_opcode_decoder_bench
